// ### verilog/nand_host_consts.vh
// Purpose: Shared constants for the NAND host controller.
// Assumes: 100 MHz clock, asynchronous NAND device with x8 or x16 data bus.
// Notes: Command codes, address layout and strobe timing counts.
//
// Summary of operation
// - Address goes out in three cycles: A0-A7, A9-A16, A17-A23 with bit 7 low.
// - Command and address use the low eight lines; upper lines held low.
// - Write strobe pulses low with chip select low; device latches on rise.
// - Command latch high means command, address latch high means address.
// - Program is 80h, address, data, then 10h confirm.
// - Erase is 60h, two row cycles, then D0h confirm.
// - Read and program send three address cycles right after the command.
// - Host issues only defined command codes.
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH

`define CMD_READ_FIRST 8'h00
`define CMD_READ_SECOND 8'h01
`define CMD_READ_SPARE 8'h50
`define CMD_READ_ID 8'h90
`define CMD_RESET 8'hFF
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS 8'h70

`define OP_READ 3'h0
`define OP_SPARE 3'h1
`define OP_ID 3'h2
`define OP_RESET 3'h3
`define OP_PROGRAM 3'h4
`define OP_ERASE 3'h5
`define OP_STATUS 3'h6
`define OP_READ_HI 3'h7

`define PAGES 32768
`define COLS_X8 528
`define COLS_X16 264
`define SPARE_X8 16
`define SPARE_X16 8
`define PAGE_BITS 15
`define COL_BITS 10

`define CLK_PERIOD_NS 10
`define STROBE_LOW_NS 30
`define STROBE_HIGH_NS 20
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_SETTLE_CYC 10

`endif

// ### verilog/word_buffer.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous inputs.
// Notes: Lets a stalled receiver hold data without losing a word.
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshake terms; full and empty come straight from the count.
  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage and pointers.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'd1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'd1;
      end
    end
  end
endmodule // word_buffer
`default_nettype wire

// ### verilog/nand_host.v
// Purpose: Host controller driving an asynchronous NAND device through its pins.
// Assumes: Device pins sampled synchronously; ready_busy is already pulled up.
// Notes: Read data passes a two-entry buffer so a stalled user loses no word.
//   A bus cycle is LOW_CYC clocks low and HIGH_CYC + 1 clocks high on the strobes.
//   The extra high clock gives the device margin between cycles at no cost in logic.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_consts.vh"
module nand_host #(
  parameter WIDE = 0,
  parameter DATA_W = 16,
  parameter LOW_CYC = `STROBE_LOW_CYC,
  parameter HIGH_CYC = `STROBE_HIGH_CYC
) (
  input wire clock,
  input wire rst,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [14:0] cmd_page,
  input wire [9:0] cmd_col,
  input wire [9:0] cmd_len,
  input wire [DATA_W-1:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output wire [DATA_W-1:0] rd_data,
  output wire rd_valid,
  input wire rd_ready,
  output wire done,
  output reg chip_select_n,
  output reg cmd_latch,
  output reg addr_latch,
  output reg write_strobe_n,
  output reg read_strobe_n,
  output reg [15:0] io_out,
  output reg io_oe,
  input wire [15:0] io_in,
  input wire ready_busy
);
  // Sequencer states; each write or read state walks one bus cycle at a time.
  localparam S_IDLE = 4'd0;
  localparam S_CMD = 4'd1;
  localparam S_ADDR = 4'd2;
  localparam S_WDATA = 4'd3;
  localparam S_CONF = 4'd4;
  localparam S_SETTLE = 4'd5;
  localparam S_WAIT = 4'd6;
  localparam S_RDATA = 4'd7;
  localparam S_DONE = 4'd8;

  // Bus cycle kinds, kept for anyone tracing the pins by hand.
  localparam [1:0] K_CMD = 2'd0;
  localparam [1:0] K_ADDR = 2'd1;
  localparam [1:0] K_DATA = 2'd2;

  // Request fields are captured once, so the user may change them after acceptance.
  reg [3:0] state_reg;
  reg [2:0] op_reg;
  reg [14:0] page_reg;
  reg [7:0] col_reg;
  reg [9:0] len_reg;
  reg [1:0] addr_idx_reg;
  reg [1:0] addr_cnt_reg;
  reg [3:0] tick_reg;
  reg phase_reg;
  reg done_reg;
  reg [3:0] settle_reg;
  reg [7:0] first_code;
  reg [7:0] conf_code;
  reg [7:0] addr_byte;
  reg [1:0] addr_need;
  wire buf_in_ready;
  reg buf_in_valid_reg;
  reg [DATA_W-1:0] buf_in_data_reg;
  wire [15:0] wide_wr;
  wire read_like;
  wire strobe_end;

  ////////////////////////////////////////////////////////////////////////
  // Command decode. Only defined codes can ever leave this block.
  always @* begin
    first_code = `CMD_READ_FIRST;
    conf_code = `CMD_PROG_CONFIRM;
    addr_need = 2'd3;
    case (op_reg)
      `OP_READ: first_code = `CMD_READ_FIRST;
      `OP_READ_HI: first_code = `CMD_READ_SECOND;
      `OP_SPARE: first_code = `CMD_READ_SPARE;
      `OP_ID: begin
        first_code = `CMD_READ_ID;
        addr_need = 2'd1;
      end
      `OP_RESET: begin
        first_code = `CMD_RESET;
        addr_need = 2'd0;
      end
      `OP_STATUS: begin
        first_code = `CMD_STATUS;
        addr_need = 2'd0;
      end
      `OP_PROGRAM: first_code = `CMD_PROG_SETUP;
      `OP_ERASE: begin
        first_code = `CMD_ERASE_SETUP;
        conf_code = `CMD_ERASE_CONFIRM;
        addr_need = 2'd2;
      end
      default: first_code = `CMD_READ_FIRST;
    endcase
  end

  // Address byte by cycle index; erase skips the column cycle.
  always @* begin
    addr_byte = 8'h00;
    case (addr_idx_reg)
      2'd0: addr_byte = col_reg;
      2'd1: addr_byte = page_reg[7:0];
      default: addr_byte = {1'b0, page_reg[14:8]};
    endcase
  end

  // Narrow data rides the low lines; the upper lines stay zero in that case.
  assign wide_wr = {{(16-DATA_W){1'b0}}, wr_data};
  // Operations that end by fetching words over the read strobe.
  assign read_like = (op_reg == `OP_READ) || (op_reg == `OP_READ_HI) ||
                     (op_reg == `OP_SPARE) || (op_reg == `OP_ID) ||
                     (op_reg == `OP_STATUS);
  assign strobe_end = phase_reg && (tick_reg == HIGH_CYC[3:0] - 4'd1);
  // Handshakes are combinational so the user sees them in the cycle they apply.
  assign cmd_ready = (state_reg == S_IDLE);
  assign wr_ready = (state_reg == S_WDATA) && phase_reg && strobe_end;
  assign done = done_reg;

  ////////////////////////////////////////////////////////////////////////
  // Main sequencer. Each bus cycle is a low phase then a high phase.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      // Park the pins idle: deselected, both strobes high and the bus released.
      state_reg <= S_IDLE;
      op_reg <= 3'd0;
      page_reg <= 15'd0;
      col_reg <= 8'd0;
      len_reg <= 10'd0;
      addr_idx_reg <= 2'd0;
      addr_cnt_reg <= 2'd0;
      tick_reg <= 4'd0;
      phase_reg <= 1'b0;
      done_reg <= 1'b0;
      settle_reg <= 4'd0;
      chip_select_n <= 1'b1;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 16'h0000;
      io_oe <= 1'b0;
      buf_in_valid_reg <= 1'b0;
      buf_in_data_reg <= {DATA_W{1'b0}};
    end else begin
      done_reg <= 1'b0;
      // The buffer takes a pending word as soon as it has room; a new capture wins.
      if (buf_in_valid_reg && buf_in_ready) begin
        buf_in_valid_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          // Deselect between requests so the device drops back to standby.
          chip_select_n <= 1'b1;
          io_oe <= 1'b0;
          if (cmd_valid) begin
            op_reg <= cmd_op;
            page_reg <= cmd_page;
            col_reg <= cmd_col[7:0];
            len_reg <= cmd_len;
            addr_idx_reg <= (cmd_op == `OP_ERASE) ? 2'd1 : 2'd0;
            addr_cnt_reg <= 2'd0;
            tick_reg <= 4'd0;
            phase_reg <= 1'b0;
            chip_select_n <= 1'b0;
            state_reg <= S_CMD;
          end
        end
        S_CMD, S_ADDR, S_WDATA, S_CONF: begin
          // Write cycle: strobe low with select low, device latches on rise.
          tick_reg <= tick_reg + 4'd1;
          if (!phase_reg && (state_reg == S_WDATA) && (tick_reg == 4'd0) && !wr_valid) begin
            // No word offered yet: the strobe stays high so stale data is never latched.
            tick_reg <= 4'd0;
          end else if (!phase_reg) begin
            // Latch terms and bus value change with the falling strobe and hold while low.
            write_strobe_n <= 1'b0;
            io_oe <= 1'b1;
            cmd_latch <= (state_reg == S_CMD) || (state_reg == S_CONF);
            addr_latch <= (state_reg == S_ADDR);
            // Only the low eight lines carry commands and addresses; the rest stay low.
            if (state_reg == S_CMD) io_out <= {8'h00, first_code};
            else if (state_reg == S_CONF) io_out <= {8'h00, conf_code};
            else if (state_reg == S_ADDR) io_out <= {8'h00, addr_byte};
            else io_out <= wide_wr;
            // The strobe fell at tick zero, so it rises after LOW_CYC whole cycles.
            if (tick_reg == LOW_CYC[3:0]) begin
              write_strobe_n <= 1'b1; // Rising edge latches the value.
              phase_reg <= 1'b1;
              tick_reg <= 4'd0;
            end
          end else if (strobe_end) begin
            // End of the high phase: drop the latch terms and choose the next step.
            phase_reg <= 1'b0;
            tick_reg <= 4'd0;
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            if (state_reg == S_CMD) begin
              // Commands without address cycles go straight to their data or wait phase.
              if (addr_need != 2'd0) state_reg <= S_ADDR;
              else if (op_reg == `OP_RESET) state_reg <= S_SETTLE;
              else state_reg <= S_RDATA;
            end else if (state_reg == S_ADDR) begin
              // Count cycles so no surplus address cycle is sent.
              addr_idx_reg <= addr_idx_reg + 2'd1;
              addr_cnt_reg <= addr_cnt_reg + 2'd1;
              // Route by operation once the last address cycle has gone out.
              if (addr_cnt_reg + 2'd1 == addr_need) begin
                if (op_reg == `OP_PROGRAM) state_reg <= S_WDATA;
                else if (op_reg == `OP_ERASE) state_reg <= S_CONF;
                else if (op_reg == `OP_ID) state_reg <= S_RDATA;
                else state_reg <= S_SETTLE; // Page load makes the device busy.
              end
            end else if (state_reg == S_WDATA) begin
              len_reg <= len_reg - 10'd1;
              if (len_reg == 10'd1) state_reg <= S_CONF;
            end else begin
              state_reg <= S_SETTLE;
            end
          end else if (state_reg == S_WDATA && !wr_valid) begin
            tick_reg <= tick_reg; // Hold the high phase until data arrives.
          end
        end
        S_SETTLE: begin
          // Ready/busy lags the last write edge (confirm, last read address or reset command), so wait before sampling it.
          io_oe <= 1'b0;
          settle_reg <= settle_reg + 4'd1;
          if (settle_reg == `BUSY_SETTLE_CYC - 1) begin
            settle_reg <= 4'd0;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Select is kept low; a busy device ignores it anyway.
          // Reset ends with done only; reads go on to fetch the loaded page.
          if (ready_busy) begin
            if (read_like && op_reg != `OP_RESET) state_reg <= S_RDATA;
            else state_reg <= S_DONE;
          end
        end
        S_RDATA: begin
          // Each read strobe fall returns the next column.
          io_oe <= 1'b0;
          tick_reg <= tick_reg + 4'd1;
          if (!phase_reg) begin
            // A full buffer with a word still pending delays the falling strobe, so no word is fetched without room.
            if (!buf_in_valid_reg || buf_in_ready) read_strobe_n <= 1'b0;
            else tick_reg <= 4'd0;
            // Sample while the strobe is still low and the device drives the bus.
            if (tick_reg == LOW_CYC[3:0]) begin
              buf_in_data_reg <= io_in[DATA_W-1:0];
              buf_in_valid_reg <= 1'b1;
              read_strobe_n <= 1'b1;
              phase_reg <= 1'b1;
              tick_reg <= 4'd0;
            end
          end else if (strobe_end) begin
            phase_reg <= 1'b0;
            tick_reg <= 4'd0;
            len_reg <= len_reg - 10'd1;
            if (len_reg <= 10'd1) state_reg <= S_DONE;
          end
        end
        default: begin
          // Finish: deselect and pulse done for one cycle.
          chip_select_n <= 1'b1;
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path buffer; the strobe stalls while it is full and a word is pending.
  word_buffer #(
    .WIDTH(DATA_W)
  ) read_buffer (
    .clock(clock),
    .rst(rst),
    .in_data(buf_in_data_reg),
    .in_valid(buf_in_valid_reg),
    .in_ready(buf_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );
endmodule // nand_host
`default_nettype wire

// ### tb/nand_host_sva.sv
// Purpose: Pin checks on the NAND host controller.
// Assumes: One clock, reset active high.
// Notes: Bound to nand_host; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module nand_host_sva #(parameter LOW_CYC = 3) (
  input wire logic clock,
  input wire logic rst,
  input wire logic done,
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [15:0] io_out,
  input wire logic io_oe,
  input wire logic ready_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] low_reg;
  logic [1:0] acnt_reg;
  // Strobe low length, and address cycles since the last command.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_reg <= 4'h0;
      acnt_reg <= 2'h0;
    end else begin
      low_reg <= write_strobe_n ? 4'h0 : low_reg + 4'h1;
      if (cmd_latch) acnt_reg <= 2'h0;
      else if (addr_latch && $fell(write_strobe_n)) acnt_reg <= acnt_reg + 2'h1;
    end
  end
  sequence strobe_low; (!write_strobe_n)[*3]; endsequence
  sequence strobe_gap; write_strobe_n[*2]; endsequence
  we_pulse_a: assert property ($fell(write_strobe_n) |-> strobe_low ##1 strobe_gap)
    else $error("write strobe pulse shape wrong");
  we_len_a: assert property ($rose(write_strobe_n) |-> low_reg == LOW_CYC)
    else $error("write strobe low time wrong");
  we_select_a: assert property (!write_strobe_n |-> !chip_select_n && io_oe)
    else $error("write without select or drive");
  we_hold_a: assert property ((!write_strobe_n)[*2] |-> $stable(io_out) && $stable(cmd_latch))
    else $error("bus moved during write strobe");
  latch_one_a: assert property (cmd_latch |-> !addr_latch)
    else $error("both latches high");
  addr_upper_a: assert property (addr_latch && !write_strobe_n |-> io_out[15:8] == 8'h00)
    else $error("upper lines not low in address");
  cmd_code_a: assert property (cmd_latch && !write_strobe_n |->
    io_out[7:0] inside {8'h00, 8'h01, 8'h50, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70})
    else $error("undefined command code");
  busy_cmd_a: assert property (!ready_busy && cmd_latch && $fell(write_strobe_n) |->
    io_out[7:0] inside {8'hFF, 8'h70})
    else $error("command sent while busy");
  addr_count_a: assert property (addr_latch && $fell(write_strobe_n) |-> acnt_reg < 2'h3)
    else $error("too many address cycles");
  rd_strobe_a: assert property ($fell(read_strobe_n) |-> !chip_select_n && !io_oe && write_strobe_n)
    else $error("read strobe while driving bus");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule // nand_host_sva
bind nand_host nand_host_sva #(.LOW_CYC(LOW_CYC)) sva_i (.clock(clock), .rst(rst), .done(done),
  .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
  .io_oe(io_oe), .ready_busy(ready_busy));
`default_nettype wire

// ### tb/nand_dev.sv
// Purpose: Behavioural byte-wide NAND device for the host bench.
// Assumes: Strobes are clean edges; no clock in the device.
// Notes: Busy time is a variable so the bench can make it slow.
`timescale 1ns/1ps
`default_nettype none
module nand_dev (
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [15:0] io_out,
  output logic [15:0] io_in,
  output logic ready_busy = 1'b1
);
  parameter logic [7:0] ID_CODE = 8'h5A; // Arbitrary identifier value.
  int busy_ns = 500;
  logic [7:0] mem [int];
  logic [7:0] pg [0:527];
  logic [7:0] cmd = 8'hFF;
  logic [7:0] dout = 8'h00;
  logic [7:0] c;
  int acnt = 0, ptr = 0, page = 0, col = 0, k;
  bit half = 0;
  // A released bus shows the inverse of the last byte so stale data never matches.
  assign io_in = {8'h00, read_strobe_n ? ~dout : dout};
  task busy;
    ready_busy = 1'b0;
    fork #(busy_ns) ready_busy = 1'b1; join_none
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Writes are taken on the rising strobe while selected.
  always @(posedge write_strobe_n) if (!chip_select_n) begin
    c = io_out[7:0];
    if (cmd_latch && (ready_busy || c == 8'hFF || c == 8'h70)) begin
      acnt = 0;
      if (c == 8'h10) begin foreach (pg[i]) mem[page * 1024 + i] = pg[i]; busy(); end
      else if (c == 8'hD0) begin
        foreach (mem[j]) if (j / 32768 == page / 32) mem[j] = 8'hFF;
        busy();
      end else cmd = c;
      if (c == 8'h00 || c == 8'h01) half = c[0];
      if (c == 8'h80) foreach (pg[i]) pg[i] = 8'hFF;
      if (c == 8'hFF) begin half = 0; busy(); end
    end else if (addr_latch && acnt < ((cmd == 8'h60) ? 2 : (cmd == 8'h90) ? 1 : 3)) begin
      k = (cmd == 8'h60) ? acnt + 1 : acnt;
      if (k == 0) col = c;
      if (k == 1) page = (page & 32'h7F00) | c;
      if (k == 2) page = (page & 32'h00FF) | (c[6:0] << 8);
      acnt++;
      if (k == 2 && cmd != 8'h60) begin
        ptr = col + ((cmd == 8'h50) ? 512 : half ? 256 : 0);
        if (cmd != 8'h80) begin
          for (int i = 0; i < 528; i++) pg[i] = mem.exists(page * 1024 + i) ? mem[page * 1024 + i] : 8'hFF;
          busy();
          half = 0;
        end
      end
    end else if (!cmd_latch && !addr_latch && ptr < 528) pg[ptr++] = c;
  end
  // Each falling read strobe presents the next byte.
  always @(negedge read_strobe_n) if (!chip_select_n) begin
    if (cmd == 8'h70) dout = {1'b1, ready_busy, 6'h00};
    else if (cmd == 8'h90) dout = ID_CODE;
    else if (ptr < 528) dout = pg[ptr++];
  end
endmodule // nand_dev
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for the NAND host controller.
// Assumes: Byte-wide device model on the far side.
// Notes: Each scenario is one task.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, rst = 1, cmd_valid = 0, wr_valid = 0, rd_ready = 1;
  logic [2:0] cmd_op = 0;
  logic [14:0] cmd_page = 0;
  logic [9:0] cmd_col = 0, cmd_len = 1;
  logic [7:0] wr_data = 0;
  wire logic [7:0] rd_data;
  wire logic [15:0] io_out, io_in;
  wire logic cmd_ready, wr_ready, rd_valid, done, chip_select_n, cmd_latch, addr_latch;
  wire logic write_strobe_n, read_strobe_n, io_oe, ready_busy;
  int mismatches = 0, n_compared = 0, cyc = 0, wi = 0, dones = 0, c0;
  bit stall = 0;
  logic [7:0] wq [$], rq [$];
  nand_host #(.WIDE(0), .DATA_W(8)) uut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_page(cmd_page), .cmd_col(cmd_col),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .done(done),
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy(ready_busy));
  nand_dev dev (.chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_in(io_in), .ready_busy(ready_busy));
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  // Feed write words, collect read words and cut a hang short.
  always @(posedge clock) begin
    cyc++;
    if (done) dones++;
    if (rd_valid && rd_ready) rq.push_back(rd_data);
    if (wr_valid && wr_ready) wi++;
    wr_data <= (wi < wq.size()) ? wq[wi] : 8'h00;
    wr_valid <= (wi < wq.size());
    rd_ready <= !stall;
    if (cyc == 60000) begin mismatches++; results(); end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One request, then a bounded wait for its done pulse.
  task run(input logic [2:0] op, input logic [14:0] pg, input logic [9:0] col, input logic [9:0] len);
    int d, n;
    d = dones;
    n = 0;
    wi = 0;
    rq.delete();
    check("accepting", cmd_ready, 1);
    cmd_op <= op; cmd_page <= pg; cmd_col <= col; cmd_len <= len;
    cmd_valid <= 1;
    @(posedge clock);
    cmd_valid <= 0;
    while (dones == d && n < 20000) begin @(posedge clock); n++; end
    check("done", dones != d, 1);
  endtask
  task get(input string what, input logic [7:0] e [$]);
    int n;
    n = 0;
    while (rq.size() < e.size() && n < 100) begin @(posedge clock); n++; end
    foreach (e[i]) check(what, (i < rq.size()) ? rq[i] : 8'hxx, e[i]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_prog;
    wq = '{8'h12, 8'h34, 8'h00, 8'hA5};
    run(3'h4, 15'h0105, 10'h003, 10'h004);
    check("stored", dev.mem[261 * 1024 + 4], 8'h34);
    wq.delete();
    run(3'h0, 15'h0105, 10'h003, 10'h004);
    get("readback", '{8'h12, 8'h34, 8'h00, 8'hA5});
    $display("test prog finished");
  endtask
  task t_halves;
    dev.mem[7 * 1024 + 256] = 8'h6C;
    dev.mem[7 * 1024] = 8'h11;
    dev.mem[7 * 1024 + 527] = 8'hE7;
    run(3'h7, 15'h0007, 10'h000, 10'h001);
    get("second half", '{8'h6C});
    check("pointer back", dev.half, 0);
    run(3'h0, 15'h0007, 10'h000, 10'h001);
    get("first half", '{8'h11});
    run(3'h1, 15'h0007, 10'h00F, 10'h001);
    get("last spare", '{8'hE7});
    $display("test halves finished");
  endtask
  task t_erase;
    run(3'h5, 15'h0005, 10'h000, 10'h001);
    run(3'h0, 15'h0007, 10'h000, 10'h001);
    get("erased", '{8'hFF});
    $display("test erase finished");
  endtask
  task t_misc;
    run(3'h2, 15'h0000, 10'h000, 10'h001);
    get("ident", '{8'h5A});
    run(3'h6, 15'h0000, 10'h000, 10'h001);
    get("status", '{8'hC0});
    run(3'h3, 15'h0000, 10'h000, 10'h001);
    check("ready", ready_busy, 1);
    $display("test misc finished");
  endtask
  task t_stall;
    for (int i = 0; i < 6; i++) dev.mem[40 * 1024 + i] = 8'h20 + i;
    stall = 1;
    fork
      run(3'h0, 15'h0028, 10'h000, 10'h006);
      begin
        repeat (300) @(posedge clock);
        check("held", rd_valid, 1);
        stall = 0;
      end
    join
    get("stalled", '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25});
    $display("test stall finished");
  endtask
  task t_slow;
    dev.busy_ns = 4000;
    wq = '{8'h5C};
    c0 = cyc;
    run(3'h4, 15'h0040, 10'h000, 10'h001);
    check("waited", (cyc - c0) >= 400, 1);
    check("slow stored", dev.mem[64 * 1024], 8'h5C);
    dev.busy_ns = 500;
    $display("test slow finished");
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 0;
    t_prog();
    t_halves();
    t_erase();
    t_misc();
    t_stall();
    t_slow();
    results();
  end
endmodule // testbench
`default_nettype wire
